// File: logic/sfs_front.sv
// Serial flash command front end: write enable latch, status read and write,
// single, dual and quad reads. Assumes an array engine answers byte reads
// over a valid/ready pair; serial pins are oversampled by the system clock.
`timescale 1ns/1ps
`default_nettype none

module sfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0]            mem_r [DEPTH];
  logic [PW-1:0]               wr_r;
  logic [PW-1:0]               rd_r;
  logic [$clog2(DEPTH+1)-1:0]  cnt_r;
  logic                        push;
  logic                        pop;

  if (DEPTH < 2) begin : g_chk
    $error("sfs_fifo needs a depth of at least two");
  end

  assign in_ready  = (cnt_r != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign count     = cnt_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module sfs_front #(
  parameter int STATUS_WRITE_TIME_NS = 5000000,
  parameter int FIFO_DEPTH           = 8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclk_pin,
  input  wire logic        cs_n_pin,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n,
  output logic             mem_req_valid,
  input  wire logic        mem_req_ready,
  output logic      [23:0] mem_req_addr,
  input  wire logic        mem_rsp_valid,
  output logic             mem_rsp_ready,
  input  wire logic [7:0]  mem_rsp_data,
  output logic             write_enable_latch,
  output logic             write_in_progress,
  output logic      [4:0]  protect_area_bits,
  output logic      [1:0]  status_protect_bits
);
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_TIME_NS + sfs_pkg::CLK_PERIOD_NS - 1) / sfs_pkg::CLK_PERIOD_NS;
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (STATUS_WRITE_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("sfs_front parameters out of range");
  end

  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io, input logic [2:0] ln);
    case (ln)
      sfs_pkg::LANES_X1: shift_in = {sh[30:0], io[0]};
      sfs_pkg::LANES_X2: shift_in = {sh[29:0], io[1:0]};
      default:           shift_in = {sh[27:0], io[3:0]};
    endcase
  endfunction

  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] ln);
    case (ln)
      sfs_pkg::LANES_X1: lane_out = {2'h0, b[7], 1'b0};
      sfs_pkg::LANES_X2: lane_out = {2'h0, b[7:6]};
      default:           lane_out = b[7:4];
    endcase
  endfunction

  function automatic logic [23:0] sel_mask(input sfs_pkg::sfs_sel_t s);
    case (s)
      sfs_pkg::SEL_LOW: sel_mask = 24'h0000ff;
      sfs_pkg::SEL_MID: sel_mask = 24'h00ff00;
      default:          sel_mask = 24'hff0000;
    endcase
  endfunction

  function automatic logic [23:0] merge(input logic [23:0] st, input logic [7:0] b, input sfs_pkg::sfs_sel_t s);
    logic [23:0] m;
    m     = sel_mask(s) & sfs_pkg::STATUS_WRITABLE;
    merge = (st & ~m) | ({b, b, b} & m);
  endfunction

  sfs_pkg::sfs_state_t state_r;
  sfs_pkg::sfs_sel_t   sel_r;
  sfs_pkg::sfs_sel_t   pend_sel_r;
  logic [5:0]          sync1_r;
  logic [5:0]          sync2_r;
  logic                sclk_d_r;
  logic                cs_d_r;
  logic [5:0]          cnt_r;
  logic [31:0]         sh_r;
  logic [2:0]          alanes_r;
  logic [2:0]          dlanes_r;
  logic [5:0]          alen_r;
  logic [5:0]          dummy_r;
  logic                mode_r;
  logic [7:0]          osh_r;
  logic [2:0]          pos_r;
  logic [3:0]          out_r;
  logic [3:0]          drive_r;
  logic                wel_r;
  logic                vol_r;
  logic                wip_r;
  logic [31:0]         tmr_r;
  logic [7:0]          pend_r;
  logic [23:0]         stat_r;
  logic [23:0]         req_addr_r;
  logic [CW:0]         inflight_r;
  logic                armed_r;
  logic [3:0]          io_s;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_rise;
  logic                op_done;
  logic [7:0]          op;
  logic [31:0]         sh_nxt;
  logic                sw_accept;
  logic                sw_done;
  logic                hw_prot;
  logic [23:0]         stat_word;
  logic [7:0]          stat_byte;
  logic                read_phase;
  logic                f_valid;
  logic [7:0]          f_data;
  logic                f_pop;
  logic                f_in_ready;
  logic [CW-1:0]       f_count;
  logic                req_fire;
  logic                rsp_fire;
  logic [7:0]          src;

  // Pin synchronisers and edge detection
  always_ff @(posedge clock) begin
    sync1_r  <= {sclk_pin, cs_n_pin, io_in};
    sync2_r  <= sync1_r;
    sclk_d_r <= sync2_r[5];
    cs_d_r   <= sync2_r[4];
  end

  assign io_s      = sync2_r[3:0];
  assign sclk_rise = sync2_r[5] & ~sclk_d_r & ~sync2_r[4];
  assign sclk_fall = ~sync2_r[5] & sclk_d_r & ~sync2_r[4];
  assign cs_rise   = sync2_r[4] & ~cs_d_r;
  assign op        = {sh_r[6:0], io_s[0]};
  assign op_done   = sclk_rise && (state_r == sfs_pkg::ST_OPCODE) && (cnt_r == sfs_pkg::OPCODE_CLKS - 6'h01);
  assign sh_nxt    = shift_in(sh_r, io_s, alanes_r);
  assign hw_prot   = stat_r[sfs_pkg::BIT_SRP0] & ~stat_r[sfs_pkg::BIT_SRP1] &
                     ~stat_r[sfs_pkg::BIT_QE] & ~io_s[sfs_pkg::WP_LANE];
  assign stat_word = {stat_r[23:2], wel_r, wip_r};

  // Command sequencer on serial rising edges
  always_ff @(posedge clock) begin
    if (rst || sync2_r[4]) begin
      state_r  <= sfs_pkg::ST_OPCODE;
      cnt_r    <= '0;
      alanes_r <= sfs_pkg::LANES_X1;
    end else if (sclk_rise) begin
      case (state_r)
        sfs_pkg::ST_OPCODE: begin
          sh_r  <= shift_in(sh_r, io_s, sfs_pkg::LANES_X1);
          cnt_r <= cnt_r + 6'h01;
          if (op_done) begin
            cnt_r    <= '0;
            state_r  <= sfs_pkg::ST_SKIP;
            alanes_r <= sfs_pkg::LANES_X1;
            dlanes_r <= sfs_pkg::LANES_X1;
            alen_r   <= sfs_pkg::ADDR_CLKS_X1;
            dummy_r  <= '0;
            mode_r   <= 1'b0;
            if (op == sfs_pkg::OP_RDSR1) begin
              state_r <= sfs_pkg::ST_STAT;
              sel_r   <= sfs_pkg::SEL_LOW;
            end else if (op == sfs_pkg::OP_RDSR2) begin
              state_r <= sfs_pkg::ST_STAT;
              sel_r   <= sfs_pkg::SEL_MID;
            end else if (op == sfs_pkg::OP_RDSR3) begin
              state_r <= sfs_pkg::ST_STAT;
              sel_r   <= sfs_pkg::SEL_HIGH;
            end else if (op == sfs_pkg::OP_WRSR1 || op == sfs_pkg::OP_WRSR2 || op == sfs_pkg::OP_WRSR3) begin
              if ((wel_r || vol_r) && !hw_prot && !wip_r) begin
                state_r <= sfs_pkg::ST_WDATA;
              end
              sel_r <= (op == sfs_pkg::OP_WRSR1) ? sfs_pkg::SEL_LOW :
                       (op == sfs_pkg::OP_WRSR2) ? sfs_pkg::SEL_MID : sfs_pkg::SEL_HIGH;
            end else if (op == sfs_pkg::OP_READ) begin
              if (!wip_r) begin
                state_r <= sfs_pkg::ST_ADDR;
              end
            end else if (op == sfs_pkg::OP_FREAD || op == sfs_pkg::OP_DOREAD) begin
              state_r  <= sfs_pkg::ST_ADDR;
              dummy_r  <= sfs_pkg::FAST_DUMMY_CLKS;
              dlanes_r <= (op == sfs_pkg::OP_DOREAD) ? sfs_pkg::LANES_X2 : sfs_pkg::LANES_X1;
            end else if (op == sfs_pkg::OP_DIOREAD) begin
              state_r  <= sfs_pkg::ST_ADDR;
              alanes_r <= sfs_pkg::LANES_X2;
              dlanes_r <= sfs_pkg::LANES_X2;
              alen_r   <= sfs_pkg::ADDR_CLKS_X2;
              mode_r   <= 1'b1;
            end else if (stat_r[sfs_pkg::BIT_QE] && op == sfs_pkg::OP_QOREAD) begin
              state_r  <= sfs_pkg::ST_ADDR;
              dummy_r  <= sfs_pkg::FAST_DUMMY_CLKS;
              dlanes_r <= sfs_pkg::LANES_X4;
            end else if (stat_r[sfs_pkg::BIT_QE] && (op == sfs_pkg::OP_QIOREAD || op == sfs_pkg::OP_QWREAD)) begin
              state_r  <= sfs_pkg::ST_ADDR;
              alanes_r <= sfs_pkg::LANES_X4;
              dlanes_r <= sfs_pkg::LANES_X4;
              alen_r   <= sfs_pkg::ADDR_CLKS_X4;
              mode_r   <= 1'b1;
              dummy_r  <= (op == sfs_pkg::OP_QIOREAD) ? sfs_pkg::QIO_DUMMY_CLKS : sfs_pkg::QWORD_DUMMY_CLKS;
            end
          end
        end
        sfs_pkg::ST_ADDR: begin
          sh_r  <= sh_nxt;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == alen_r - 6'h01) begin
            cnt_r      <= '0;
            state_r    <= (dummy_r != '0) ? sfs_pkg::ST_DUMMY : sfs_pkg::ST_DATA;
            req_addr_r <= mode_r ? sh_nxt[31:8] : sh_nxt[23:0];
          end
        end
        sfs_pkg::ST_DUMMY: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == dummy_r - 6'h01) begin
            state_r <= sfs_pkg::ST_DATA;
          end
        end
        sfs_pkg::ST_WDATA: begin
          sh_r <= shift_in(sh_r, io_s, sfs_pkg::LANES_X1);
          if (cnt_r != 6'h3f) begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        default: begin
        end
      endcase
    end
    if (req_fire) begin
      req_addr_r <= req_addr_r + 24'h000001;
    end
  end

  // Write enable latch and volatile qualifier
  always_ff @(posedge clock) begin
    if (rst) begin
      wel_r <= 1'b0;
    end else if (op_done && op == sfs_pkg::OP_WREN) begin
      wel_r <= 1'b1;
    end else if ((op_done && op == sfs_pkg::OP_WRDI) || sw_done) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      vol_r <= 1'b0;
    end else if (op_done && op == sfs_pkg::OP_VWREN) begin
      vol_r <= 1'b1;
    end else if (sw_done) begin
      vol_r <= 1'b0;
    end
  end

  // Status write cycle
  assign sw_accept = cs_rise && (state_r == sfs_pkg::ST_WDATA) && (cnt_r == sfs_pkg::WDATA_CLKS);
  assign sw_done   = (sw_accept && vol_r) || (wip_r && tmr_r == '0);

  always_ff @(posedge clock) begin
    if (rst) begin
      wip_r <= 1'b0;
      tmr_r <= '0;
    end else if (sw_accept && !vol_r) begin
      wip_r      <= 1'b1;
      tmr_r      <= 32'(STATUS_WRITE_CYCLES - 1);
      pend_r     <= sh_r[7:0];
      pend_sel_r <= sel_r;
    end else if (wip_r) begin
      if (tmr_r == '0) begin
        wip_r <= 1'b0;
      end else begin
        tmr_r <= tmr_r - 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_r <= sfs_pkg::STATUS_RESET;
    end else if (sw_accept && vol_r) begin
      stat_r <= merge(stat_r, sh_r[7:0], sel_r);
    end else if (wip_r && tmr_r == '0) begin
      stat_r <= merge(stat_r, pend_r, pend_sel_r);
    end
  end

  assign write_enable_latch  = wel_r;
  assign write_in_progress   = wip_r;
  assign protect_area_bits   = stat_r[sfs_pkg::BIT_BP_LO +: 5];
  assign status_protect_bits = {stat_r[sfs_pkg::BIT_SRP1], stat_r[sfs_pkg::BIT_SRP0]};

  // Array fetch ahead of the serial output
  assign read_phase    = (state_r == sfs_pkg::ST_DUMMY) || (state_r == sfs_pkg::ST_DATA);
  assign mem_req_valid = read_phase && armed_r && (({1'b0, f_count} + inflight_r) < (CW+1)'(FIFO_DEPTH));
  assign mem_req_addr  = req_addr_r;
  assign req_fire      = mem_req_valid & mem_req_ready;
  assign mem_rsp_ready = armed_r ? f_in_ready : 1'b1;
  assign rsp_fire      = mem_rsp_valid & mem_rsp_ready;

  always_ff @(posedge clock) begin
    if (rst) begin
      armed_r    <= 1'b0;
      inflight_r <= '0;
    end else begin
      armed_r    <= read_phase && (armed_r || inflight_r == '0);
      inflight_r <= inflight_r + (CW+1)'(req_fire) - (CW+1)'(rsp_fire);
    end
  end

  sfs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .flush     (!read_phase),
    .in_valid  (mem_rsp_valid & armed_r),
    .in_ready  (f_in_ready),
    .in_data   (mem_rsp_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data),
    .count     (f_count)
  );

  // Output serializer on serial falling edges
  always_comb begin
    case (sel_r)
      sfs_pkg::SEL_LOW: stat_byte = stat_word[7:0];
      sfs_pkg::SEL_MID: stat_byte = stat_word[15:8];
      default:          stat_byte = stat_word[23:16];
    endcase
  end

  assign src   = (state_r == sfs_pkg::ST_STAT) ? stat_byte : (f_valid ? f_data : 8'h00);
  assign f_pop = sclk_fall && (state_r == sfs_pkg::ST_DATA) && (pos_r == '0);

  always_ff @(posedge clock) begin
    if (rst || sync2_r[4]) begin
      pos_r   <= '0;
      out_r   <= '0;
      drive_r <= '0;
    end else if (sclk_fall && (state_r == sfs_pkg::ST_DATA || state_r == sfs_pkg::ST_STAT)) begin
      drive_r <= (dlanes_r == sfs_pkg::LANES_X1) ? sfs_pkg::DRIVE_X1 :
                 (dlanes_r == sfs_pkg::LANES_X2) ? sfs_pkg::DRIVE_X2 : sfs_pkg::DRIVE_X4;
      pos_r   <= pos_r + dlanes_r;
      if (pos_r == '0) begin
        out_r <= lane_out(src, dlanes_r);
        osh_r <= src << dlanes_r;
      end else begin
        out_r <= lane_out(osh_r, dlanes_r);
        osh_r <= osh_r << dlanes_r;
      end
    end
  end

  assign io_out  = out_r;
  assign io_oe_n = ~drive_r;
endmodule

`default_nettype wire

// File: pkg/sfs_pkg.sv
// Constants, opcodes and types for the serial flash status and read front end.
// Assumes a 200 MHz system clock that oversamples the serial link.
package sfs_pkg;

  // Instruction codes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_VWREN   = 8'h50;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_RDSR3   = 8'h15;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  localparam logic [7:0] OP_WRSR3   = 8'h11;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FREAD   = 8'h0b;
  localparam logic [7:0] OP_DOREAD  = 8'h3b;
  localparam logic [7:0] OP_QOREAD  = 8'h6b;
  localparam logic [7:0] OP_DIOREAD = 8'hbb;
  localparam logic [7:0] OP_QIOREAD = 8'heb;
  localparam logic [7:0] OP_QWREAD  = 8'he7;

  // Timing
  localparam int CLK_PERIOD_NS = 5;

  // Phase lengths in serial clocks
  localparam logic [5:0] OPCODE_CLKS      = 6'h08;
  localparam logic [5:0] WDATA_CLKS       = 6'h08;
  localparam logic [5:0] ADDR_CLKS_X1     = 6'h18;
  localparam logic [5:0] ADDR_CLKS_X2     = 6'h10;
  localparam logic [5:0] ADDR_CLKS_X4     = 6'h08;
  localparam logic [5:0] FAST_DUMMY_CLKS  = 6'h08;
  localparam logic [5:0] QIO_DUMMY_CLKS   = 6'h04;
  localparam logic [5:0] QWORD_DUMMY_CLKS = 6'h02;

  // Lane widths and lane masks
  localparam logic [2:0] LANES_X1  = 3'h1;
  localparam logic [2:0] LANES_X2  = 3'h2;
  localparam logic [2:0] LANES_X4  = 3'h4;
  localparam logic [3:0] DRIVE_X1  = 4'h2;
  localparam logic [3:0] DRIVE_X2  = 4'h3;
  localparam logic [3:0] DRIVE_X4  = 4'hf;
  localparam int         WP_LANE   = 2;

  // Status register layout
  localparam int          ADDR_W          = 24;
  localparam int          STATUS_W        = 24;
  localparam int          BIT_WIP         = 0;
  localparam int          BIT_WEL         = 1;
  localparam int          BIT_BP_LO       = 2;
  localparam int          BIT_SRP0        = 7;
  localparam int          BIT_SRP1        = 8;
  localparam int          BIT_QE          = 9;
  localparam logic [23:0] STATUS_RESET    = 24'h000000;
  localparam logic [23:0] STATUS_WRITABLE = 24'h607ffc;

  // Which status byte a read or write addresses
  typedef enum logic [1:0] {SEL_LOW, SEL_MID, SEL_HIGH} sfs_sel_t;

  typedef enum {ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_STAT, ST_WDATA, ST_SKIP} sfs_state_t;

endpackage

// File: tb/sfs_front_assertions.sv
// Checker for the serial flash front end, bound to every sfs_front instance.
// Assumes the host keeps chip select high at least 8 clocks between frames.
`timescale 1ns/1ps
`default_nettype none
module sfs_front_assertions #(
  parameter int STATUS_WRITE_TIME_NS = 5000000,
  parameter int FIFO_DEPTH           = 8
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        sclk_pin,
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe_n,
  input wire logic        mem_req_valid,
  input wire logic        mem_req_ready,
  input wire logic [23:0] mem_req_addr,
  input wire logic        write_enable_latch,
  input wire logic        write_in_progress,
  input wire logic [4:0]  protect_area_bits,
  input wire logic [1:0]  status_protect_bits
);
  localparam int BUSY_CLKS = STATUS_WRITE_TIME_NS / sfs_pkg::CLK_PERIOD_NS;
  logic [31:0] busy_cnt_r;
  logic [23:0] last_addr_r;
  logic        have_addr_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Length of the current busy window
  always_ff @(posedge clock) begin
    busy_cnt_r <= (rst || !write_in_progress) ? 32'h0 : busy_cnt_r + 32'h1;
  end
  // Last accepted array address within the frame
  always_ff @(posedge clock) begin
    if (mem_req_valid && mem_req_ready) begin
      last_addr_r <= mem_req_addr;
    end
    have_addr_r <= !(rst || cs_n_pin) && (have_addr_r || (mem_req_valid && mem_req_ready));
  end
  sequence cs_idle_s;
    cs_n_pin [*6];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    io_oe_n == 4'hf && !write_enable_latch && !write_in_progress && !mem_req_valid)
    else $error("reset left state set");
  busy_length_a: assert property ($fell(write_in_progress) |->
    busy_cnt_r >= BUSY_CLKS - 1 && busy_cnt_r <= BUSY_CLKS + 1)
    else $error("busy window length wrong");
  busy_needs_latch_a: assert property ($rose(write_in_progress) |-> write_enable_latch && cs_n_pin)
    else $error("busy without latch or frame end");
  latch_clear_end_a: assert property ($fell(write_in_progress) |-> !write_enable_latch)
    else $error("latch kept after write cycle");
  protect_idle_a: assert property (!$stable({protect_area_bits, status_protect_bits}) |->
    cs_n_pin && !write_in_progress)
    else $error("protect bits changed mid frame");
  lanes_release_a: assert property (cs_idle_s |-> io_oe_n == 4'hf)
    else $error("lanes driven after frame end");
  out_on_low_a: assert property (!$stable(io_out) |-> !sclk_pin)
    else $error("output changed while serial clock high");
  addr_step_a: assert property (mem_req_valid && mem_req_ready && have_addr_r |->
    mem_req_addr == last_addr_r + 24'h1)
    else $error("array address did not step by one");
endmodule
bind sfs_front sfs_front_assertions #(.STATUS_WRITE_TIME_NS(STATUS_WRITE_TIME_NS), .FIFO_DEPTH(FIFO_DEPTH))
  u_sfs_front_assertions (.clock(clock), .rst(rst), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
  .io_out(io_out), .io_oe_n(io_oe_n), .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
  .mem_req_addr(mem_req_addr), .write_enable_latch(write_enable_latch),
  .write_in_progress(write_in_progress), .protect_area_bits(protect_area_bits),
  .status_protect_bits(status_protect_bits));
`default_nettype wire

// File: tb/sfs_front_bench.sv
// Bench for the serial flash front end: latch, status and read instructions.
// Assumes sfs_host drives the link; an array model here answers byte reads.
`timescale 1ns/1ps
`default_nettype none
module sfs_front_bench;
  localparam int WR_NS   = 20000;
  localparam int WR_CLKS = WR_NS / sfs_pkg::CLK_PERIOD_NS;
  logic        clock;
  logic        rst = 1'b1;
  logic        sclk_pin, cs_n_pin, mem_req_valid, mem_rsp_ready, write_enable_latch, write_in_progress;
  logic        mem_req_ready = 1'b0;
  logic        mem_rsp_valid = 1'b0;
  logic [7:0]  mem_rsp_data = 8'h00;
  logic [3:0]  io_in, io_out, io_oe_n, q;
  logic [23:0] mem_req_addr;
  logic [23:0] pend_q [$];
  logic [4:0]  protect_area_bits;
  logic [1:0]  status_protect_bits;
  logic [7:0]  rop [7] = '{sfs_pkg::OP_READ, sfs_pkg::OP_FREAD, sfs_pkg::OP_DOREAD, sfs_pkg::OP_QOREAD,
                           sfs_pkg::OP_DIOREAD, sfs_pkg::OP_QIOREAD, sfs_pkg::OP_QWREAD};
  int          rw [7] = '{1, 1, 2, 4, 2, 4, 4};
  int          aw [7] = '{1, 1, 1, 1, 2, 4, 4};
  int          dum [7] = '{0, 1, 1, 1, 1, 3, 2};
  int          fails = 0;
  int          checked = 0;
  sfs_front #(.STATUS_WRITE_TIME_NS(WR_NS), .FIFO_DEPTH(8)) u_sfs_front (.clock(clock), .rst(rst),
    .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_ready(mem_rsp_ready), .mem_rsp_data(mem_rsp_data),
    .write_enable_latch(write_enable_latch), .write_in_progress(write_in_progress),
    .protect_area_bits(protect_area_bits), .status_protect_bits(status_protect_bits));
  sfs_host u_sfs_host (.clock(clock), .io_out(io_out), .io_oe_n(io_oe_n), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .io_in(io_in));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [7:0] md(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  // Array model: request side stalls every other cycle
  always @(posedge clock) begin
    if (rst) begin
      pend_q.delete();
    end else begin
      if (mem_rsp_valid && mem_rsp_ready) void'(pend_q.pop_front());
      if (mem_req_valid && mem_req_ready) pend_q.push_back(mem_req_addr);
    end
    mem_req_ready <= !rst && !mem_req_ready;
    mem_rsp_valid <= pend_q.size() > 0;
    mem_rsp_data  <= (pend_q.size() > 0) ? md(pend_q[0]) : ~mem_rsp_data;
  end
  task automatic print_verdict();
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [7:0] c);
    u_sfs_host.start();
    u_sfs_host.tx(c, 1);
    u_sfs_host.stop();
  endtask
  task automatic wrsr(input logic [7:0] c, input logic [7:0] d, input logic en);
    if (en) op(sfs_pkg::OP_WREN);
    u_sfs_host.start();
    u_sfs_host.tx(c, 1);
    u_sfs_host.tx(d, 1);
    u_sfs_host.stop();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < WR_CLKS + 200) begin
      @(posedge clock);
      n++;
    end
    if (write_in_progress !== 1'b0) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [23:0] a, input int na, input int nd, input int w,
                    input int n, input logic [7:0] e);
    logic [7:0] b;
    u_sfs_host.start();
    u_sfs_host.tx(c, 1);
    for (int i = 2; i >= 0 && na > 0; i--) u_sfs_host.tx(a[8*i +: 8], na);
    repeat (nd) u_sfs_host.tx(8'h00, na);
    for (int k = 0; k < n; k++) begin
      u_sfs_host.rx(w, b);
      chk(b, (na > 0) ? md(a + 24'(k)) : e);
    end
    u_sfs_host.stop();
  endtask
  initial begin
    #450000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk({2'h0, write_enable_latch, write_in_progress, io_oe_n}, 8'h0f);
    op(sfs_pkg::OP_WREN);
    chk({7'h0, write_enable_latch}, 8'h01);
    rd(sfs_pkg::OP_RDSR1, 24'h0, 0, 0, 1, 2, 8'h02);
    op(sfs_pkg::OP_WRDI);
    chk({7'h0, write_enable_latch}, 8'h00);
    wrsr(sfs_pkg::OP_WRSR1, 8'hff, 1'b0);
    chk({write_in_progress, protect_area_bits, status_protect_bits}, 8'h00);
    wrsr(sfs_pkg::OP_WRSR1, 8'hff, 1'b1);
    rd(sfs_pkg::OP_RDSR1, 24'h0, 0, 0, 1, 2, 8'h03);
    u_sfs_host.start();
    u_sfs_host.tx(sfs_pkg::OP_READ, 1);
    repeat (4) u_sfs_host.tx(8'h00, 1);
    chk({3'h0, mem_req_valid, io_oe_n}, 8'h0f);
    u_sfs_host.stop();
    wait_idle();
    chk({write_enable_latch, protect_area_bits, status_protect_bits}, 8'h7d);
    rd(sfs_pkg::OP_RDSR1, 24'h0, 0, 0, 1, 1, 8'hfc);
    u_sfs_host.wp_r = 1'b0;
    wrsr(sfs_pkg::OP_WRSR1, 8'h00, 1'b1);
    chk({write_in_progress, protect_area_bits, status_protect_bits}, 8'h7d);
    u_sfs_host.wp_r = 1'b1;
    op(sfs_pkg::OP_WREN);
    u_sfs_host.start();
    u_sfs_host.tx(sfs_pkg::OP_WRSR1, 1);
    u_sfs_host.tx(8'h00, 1);
    u_sfs_host.cyc(4'h4, 4'h5, q);
    u_sfs_host.stop();
    chk({write_in_progress, protect_area_bits, status_protect_bits}, 8'h7d);
    wrsr(sfs_pkg::OP_WRSR2, 8'h82, 1'b1);
    wait_idle();
    wrsr(sfs_pkg::OP_WRSR3, 8'hff, 1'b1);
    wait_idle();
    rd(sfs_pkg::OP_RDSR2, 24'h0, 0, 0, 1, 1, 8'h02);
    rd(sfs_pkg::OP_RDSR3, 24'h0, 0, 0, 1, 1, 8'h60);
    op(sfs_pkg::OP_VWREN);
    chk({7'h0, write_enable_latch}, 8'h00);
    wrsr(sfs_pkg::OP_WRSR1, 8'h00, 1'b0);
    chk({write_in_progress, protect_area_bits, status_protect_bits}, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(rop[i], 24'h00fffa + 24'(i) * 24'h111111, aw[i], dum[i], rw[i], (i == 0) ? 10 : 3, 8'h00);
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// File: tb/sfs_host.sv
// Host model of the serial link: mode 0 clock, chip select and lane drive.
// Assumes a lane enable is low while the device drives that lane.
`timescale 1ns/1ps
`default_nettype none
module sfs_host (
  input  wire logic       clock,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  output logic            sclk_pin,
  output logic            cs_n_pin,
  output logic      [3:0] io_in
);
  logic [3:0] drv_r = 4'h0;
  logic       wp_r  = 1'b1;
  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
  end
  // Lanes the host leaves free toggle each serial clock
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv_r);
  // One serial clock: data set while low, lanes sampled at the rise
  task automatic cyc(input logic [3:0] d, input logic [3:0] m, output logic [3:0] q);
    @(posedge clock);
    sclk_pin <= 1'b0;
    drv_r    <= (d & m) | (~drv_r & ~m);
    repeat (13) @(posedge clock);
    q = io_in;
    sclk_pin <= 1'b1;
    repeat (11) @(posedge clock);
  endtask
  task automatic tx(input logic [7:0] b, input int w);
    logic [3:0] q;
    for (int i = 0; i < 8 / w; i++) begin
      if (w == 4) cyc(b[7-4*i -: 4], 4'hf, q);
      else if (w == 2) cyc({1'b0, wp_r, b[7-2*i -: 2]}, 4'h7, q);
      else cyc({1'b0, wp_r, 1'b0, b[7-i]}, 4'h5, q);
    end
  endtask
  task automatic rx(input int w, output logic [7:0] b);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      cyc({1'b0, wp_r, 2'b00}, (w == 4) ? 4'h0 : 4'h4, q);
      b = (w == 4) ? {b[3:0], q} : (w == 2) ? {b[5:0], q[1:0]} : {b[6:0], q[1]};
    end
  endtask
  task automatic start();
    @(posedge clock);
    cs_n_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic stop();
    @(posedge clock);
    sclk_pin <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n_pin <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire
